//--- rtl/hsct_params.svh
// Purpose: Constants for the heatseal cycle timer
// Assumes: 100 MHz clk_sys, times in 0.1 s ticks, temperatures in whole degC
// Notes: Settings are clamped to their legal ranges on load
// Functional notes
// - Timer always active, start launches timeout
// - Start released early aborts the timeout
// - Phases run delay, heating, then cooling
// - Manual heat key never starts timeout
// - Only start release or reset aborts
// - Starting delay 0 to 9.9 s, default 0
// - Sealing time 0 to 99.9 s, default 1.0
// - Absolute mode ends below cooling threshold
// - Relative mode ends at percent of target
// - Timed mode ends after programmed time
// - Cooling mode change reinitialises cooling value
// - Threshold min 50 C, capped by max/range
// - Cooling percent 40 to 100, default 40
// - Cooling time 0 to 99.9 s, default 10.0
// - Range 200/300/400/500 C, default 300
// - Coefficient presets or variable, default 1100
// - Variable coefficient 400 to 4000, only if variable
// - Factory restore keeps only the language
// - Countdown and phase indicator, cleared after cooling
// - Relay icon follows relay contact exactly
// - Sealing time starts at heating or 95 percent
`ifndef HSCT_PARAMS_SVH
`define HSCT_PARAMS_SVH
`define HSCT_CLK_HZ          100000000
`define HSCT_TICK_S_DIV      10
`define HSCT_TICK_CYCLES     (`HSCT_CLK_HZ / `HSCT_TICK_S_DIV)
`define HSCT_DELAY_MAX       10'h063
`define HSCT_DELAY_DEF       10'h000
`define HSCT_SEAL_MAX        10'h3e7
`define HSCT_SEAL_DEF        10'h00a
`define HSCT_CTIME_MAX       10'h3e7
`define HSCT_CTIME_DEF       10'h064
`define HSCT_CTEMP_MIN       10'h032
`define HSCT_PCT_MIN         10'h028
`define HSCT_PCT_MAX         10'h064
`define HSCT_PCT_REACH       10'h05f
`define HSCT_PCT_DIV         10'h064
`define HSCT_TC_VAR_MIN      12'h190
`define HSCT_TC_VAR_MAX      12'hfa0
`define HSCT_TC_VAR_DEF      12'h44c
`define HSCT_RANGE_200       10'h0c8
`define HSCT_RANGE_300       10'h12c
`define HSCT_RANGE_400       10'h190
`define HSCT_RANGE_500       10'h1f4
`define HSCT_TC_780          12'h30c
`define HSCT_TC_1100         12'h44c
`define HSCT_TC_1400         12'h578
`define HSCT_TC_1700         12'h6a4
`define HSCT_TC_3500         12'hdac
`endif

//--- rtl/hsct_pkg.sv
// Purpose: Types for the heatseal cycle timer
// Assumes: Used with hsct_params.svh
// Notes: Settings travel as one packed struct
package hsct_pkg;
    typedef enum logic [4:0] {
        HSCT_IDLE  = 5'b00001,
        HSCT_DELAY = 5'b00010,
        HSCT_WAIT  = 5'b00100,
        HSCT_HEAT  = 5'b01000,
        HSCT_COOL  = 5'b10000
    } hsct_state_t;
    typedef enum logic [1:0] {
        HSCT_COOL_ABS  = 2'h0,
        HSCT_COOL_REL  = 2'h1,
        HSCT_COOL_TIME = 2'h2
    } hsct_cmode_t;
    typedef enum logic [1:0] {
        HSCT_RNG_200 = 2'h0,
        HSCT_RNG_300 = 2'h1,
        HSCT_RNG_400 = 2'h2,
        HSCT_RNG_500 = 2'h3
    } hsct_range_t;
    typedef enum logic [2:0] {
        HSCT_TC_P780  = 3'h0,
        HSCT_TC_P1100 = 3'h1,
        HSCT_TC_P1400 = 3'h2,
        HSCT_TC_P1700 = 3'h3,
        HSCT_TC_P3500 = 3'h4,
        HSCT_TC_VAR   = 3'h5
    } hsct_tcsel_t;
    typedef struct packed {
        logic [9:0]  start_delay;
        logic [9:0]  seal_time;
        hsct_cmode_t cool_mode;
        logic [9:0]  cool_value;
        hsct_range_t temp_range;
        logic [9:0]  temp_max;
        hsct_tcsel_t tc_sel;
        logic [11:0] tc_var;
        logic        seal_at_temp;
        logic [3:0]  language;
    } hsct_cfg_t;
endpackage

//--- rtl/hsct_cycle_timer.sv
// Purpose: Heatseal cycle sequencer and settings store
// Assumes: Temperatures synchronous, whole degC, settings loaded by strobe
// Notes: Manual heat only drives heat request outside a cycle
`timescale 1ns/10ps
`default_nettype none
`include "hsct_params.svh"
module hsct_cycle_timer (
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              start_in,
    input  wire logic              manual_heat_key,
    input  wire logic              cfg_load,
    input  var  hsct_pkg::hsct_cfg_t cfg_in,
    input  wire logic              factory_restore,
    input  wire logic [9:0]        target_temp,
    input  wire logic [9:0]        actual_temp,
    output var  hsct_pkg::hsct_cfg_t cfg_out,
    output logic [11:0]            band_tc,
    output logic                   heat_req,
    output logic                   output_relay,
    output logic                   relay_icon,
    output logic                   ind_heat,
    output logic                   ind_cool,
    output logic                   cycle_done,
    output logic [9:0]             seal_remain
);
    hsct_pkg::hsct_cfg_t   cfg_reg, cfg_next;
    hsct_pkg::hsct_state_t st_reg, st_next;
    logic        start_s_reg, start_s_next, start_d_reg, start_d_next;
    logic [23:0] div_reg, div_next;
    logic [9:0]  cnt_reg, cnt_next;
    logic [9:0]  rem_reg, rem_next;
    logic        done_reg, done_next;
    logic        tick;
    logic        reached;
    logic [9:0]  cap;

    function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo,
                                           input logic [9:0] hi);
        clamp10 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [9:0] range_deg(input hsct_pkg::hsct_range_t r);
        case (r)
            hsct_pkg::HSCT_RNG_200: range_deg = `HSCT_RANGE_200;
            hsct_pkg::HSCT_RNG_400: range_deg = `HSCT_RANGE_400;
            hsct_pkg::HSCT_RNG_500: range_deg = `HSCT_RANGE_500;
            default:                range_deg = `HSCT_RANGE_300;
        endcase
    endfunction

    function automatic logic [9:0] cool_default(input hsct_pkg::hsct_cmode_t m);
        case (m)
            hsct_pkg::HSCT_COOL_REL:  cool_default = `HSCT_PCT_MIN;
            hsct_pkg::HSCT_COOL_TIME: cool_default = `HSCT_CTIME_DEF;
            default:                  cool_default = `HSCT_CTEMP_MIN;
        endcase
    endfunction

    // Actual at or above pct of target
    function automatic logic pct_reached(input logic [9:0] act, input logic [9:0] tgt,
                                         input logic [9:0] pct);
        logic [19:0] lhs;
        logic [19:0] rhs;
        lhs = act * `HSCT_PCT_DIV;
        rhs = tgt * pct;
        pct_reached = (lhs >= rhs);
    endfunction

    function automatic hsct_pkg::hsct_cfg_t cfg_default(input logic [3:0] lang);
        hsct_pkg::hsct_cfg_t c;
        c.start_delay  = `HSCT_DELAY_DEF;
        c.seal_time    = `HSCT_SEAL_DEF;
        c.cool_mode    = hsct_pkg::HSCT_COOL_ABS;
        c.cool_value   = `HSCT_CTEMP_MIN;
        c.temp_range   = hsct_pkg::HSCT_RNG_300;
        c.temp_max     = `HSCT_RANGE_300;
        c.tc_sel       = hsct_pkg::HSCT_TC_P1100;
        c.tc_var       = `HSCT_TC_VAR_DEF;
        c.seal_at_temp = 1'b1;
        c.language     = lang;
        cfg_default = c;
    endfunction

    // Settings store
    always_comb begin
        cfg_next = cfg_reg;
        cap = (cfg_in.temp_max < range_deg(cfg_in.temp_range)) ? cfg_in.temp_max
              : range_deg(cfg_in.temp_range);
        if (factory_restore) begin
            cfg_next = cfg_default(cfg_reg.language);
        end else if (cfg_load) begin
            cfg_next.language     = cfg_in.language;
            cfg_next.seal_at_temp = cfg_in.seal_at_temp;
            cfg_next.temp_range   = cfg_in.temp_range;
            cfg_next.temp_max     = clamp10(cfg_in.temp_max, `HSCT_CTEMP_MIN,
                                            range_deg(cfg_in.temp_range));
            cfg_next.start_delay  = clamp10(cfg_in.start_delay, `HSCT_DELAY_DEF,
                                            `HSCT_DELAY_MAX);
            cfg_next.seal_time    = clamp10(cfg_in.seal_time, `HSCT_DELAY_DEF,
                                            `HSCT_SEAL_MAX);
            cfg_next.tc_sel = (cfg_in.tc_sel > hsct_pkg::HSCT_TC_VAR) ?
                              hsct_pkg::HSCT_TC_P1100 : cfg_in.tc_sel;
            if (cfg_in.tc_sel == hsct_pkg::HSCT_TC_VAR) begin
                cfg_next.tc_var = (cfg_in.tc_var < `HSCT_TC_VAR_MIN) ? `HSCT_TC_VAR_MIN :
                                  ((cfg_in.tc_var > `HSCT_TC_VAR_MAX) ? `HSCT_TC_VAR_MAX :
                                   cfg_in.tc_var);
            end
            cfg_next.cool_mode = (cfg_in.cool_mode == 2'h3) ? hsct_pkg::HSCT_COOL_ABS
                                 : cfg_in.cool_mode;
            if (cfg_next.cool_mode != cfg_reg.cool_mode) begin
                cfg_next.cool_value = cool_default(cfg_next.cool_mode);
            end else begin
                case (cfg_next.cool_mode)
                    hsct_pkg::HSCT_COOL_REL:
                        cfg_next.cool_value = clamp10(cfg_in.cool_value, `HSCT_PCT_MIN,
                                                      `HSCT_PCT_MAX);
                    hsct_pkg::HSCT_COOL_TIME:
                        cfg_next.cool_value = clamp10(cfg_in.cool_value, `HSCT_DELAY_DEF,
                                                      `HSCT_CTIME_MAX);
                    default:
                        cfg_next.cool_value = clamp10(cfg_in.cool_value, `HSCT_CTEMP_MIN,
                                                      cap);
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_reg <= cfg_default(4'h0);
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    always_comb begin
        case (cfg_reg.tc_sel)
            hsct_pkg::HSCT_TC_P780:  band_tc = `HSCT_TC_780;
            hsct_pkg::HSCT_TC_P1400: band_tc = `HSCT_TC_1400;
            hsct_pkg::HSCT_TC_P1700: band_tc = `HSCT_TC_1700;
            hsct_pkg::HSCT_TC_P3500: band_tc = `HSCT_TC_3500;
            hsct_pkg::HSCT_TC_VAR:   band_tc = cfg_reg.tc_var;
            default:                 band_tc = `HSCT_TC_1100;
        endcase
    end
    assign cfg_out = cfg_reg;

    // Sequencer
    assign reached = pct_reached(actual_temp, target_temp, `HSCT_PCT_REACH);
    assign tick = (div_reg == 24'(`HSCT_TICK_CYCLES - 1));

    always_comb begin
        st_next      = st_reg;
        cnt_next     = cnt_reg;
        rem_next     = rem_reg;
        done_next    = 1'b0;
        start_s_next = start_in;
        start_d_next = start_s_reg;
        div_next     = tick ? 24'h000000 : div_reg + 24'h000001;
        if (tick) begin
            cnt_next = cnt_reg + 10'h001;
        end
        case (st_reg)
            hsct_pkg::HSCT_IDLE: begin
                if (start_s_reg && !start_d_reg) begin
                    st_next  = hsct_pkg::HSCT_DELAY;
                    cnt_next = 10'h000;
                    div_next = 24'h000000;
                    rem_next = cfg_reg.seal_time;
                end
            end
            hsct_pkg::HSCT_DELAY: begin
                if (cnt_reg >= cfg_reg.start_delay) begin
                    st_next  = cfg_reg.seal_at_temp ? hsct_pkg::HSCT_WAIT
                               : hsct_pkg::HSCT_HEAT;
                    cnt_next = 10'h000;
                    div_next = 24'h000000;
                end
            end
            hsct_pkg::HSCT_WAIT: begin
                cnt_next = 10'h000;
                div_next = 24'h000000;
                if (reached) begin
                    st_next = hsct_pkg::HSCT_HEAT;
                end
            end
            hsct_pkg::HSCT_HEAT: begin
                rem_next = (cfg_reg.seal_time > cnt_reg) ? cfg_reg.seal_time - cnt_reg
                           : 10'h000;
                if (cnt_reg >= cfg_reg.seal_time) begin
                    st_next  = hsct_pkg::HSCT_COOL;
                    cnt_next = 10'h000;
                    div_next = 24'h000000;
                    rem_next = 10'h000;
                end
            end
            hsct_pkg::HSCT_COOL: begin
                case (cfg_reg.cool_mode)
                    hsct_pkg::HSCT_COOL_REL:
                        done_next = ((20'(actual_temp) * 20'(`HSCT_PCT_DIV)) <=
                                     (20'(target_temp) * 20'(cfg_reg.cool_value)));
                    hsct_pkg::HSCT_COOL_TIME:
                        done_next = (cnt_reg >= cfg_reg.cool_value);
                    default:
                        done_next = (actual_temp < cfg_reg.cool_value);
                endcase
                if (done_next) begin
                    st_next = hsct_pkg::HSCT_IDLE;
                end
            end
            default: st_next = hsct_pkg::HSCT_IDLE;
        endcase
        if (st_reg != hsct_pkg::HSCT_IDLE && !start_s_reg) begin
            st_next   = hsct_pkg::HSCT_IDLE;
            done_next = 1'b0;
            rem_next  = 10'h000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg      <= hsct_pkg::HSCT_IDLE;
            start_s_reg <= 1'b0;
            start_d_reg <= 1'b0;
            div_reg     <= 24'h000000;
            cnt_reg     <= 10'h000;
            rem_reg     <= 10'h000;
            done_reg    <= 1'b0;
        end else begin
            st_reg      <= st_next;
            start_s_reg <= start_s_next;
            start_d_reg <= start_d_next;
            div_reg     <= div_next;
            cnt_reg     <= cnt_next;
            rem_reg     <= rem_next;
            done_reg    <= done_next;
        end
    end

    assign heat_req = (st_reg == hsct_pkg::HSCT_WAIT) || (st_reg == hsct_pkg::HSCT_HEAT)
                      || ((st_reg == hsct_pkg::HSCT_IDLE) && manual_heat_key);
    assign output_relay = (st_reg != hsct_pkg::HSCT_IDLE);
    assign relay_icon   = output_relay;
    assign ind_heat     = (st_reg == hsct_pkg::HSCT_WAIT) || (st_reg == hsct_pkg::HSCT_HEAT);
    assign ind_cool     = (st_reg == hsct_pkg::HSCT_COOL);
    assign cycle_done   = done_reg;
    assign seal_remain  = rem_reg;
endmodule
`default_nettype wire

//--- verification/hsct_cycle_timer_sva.sv
// Purpose: Port checks for the cycle timer
// Assumes: Bound to hsct_cycle_timer, one clock
// Notes: Idle means output_relay low
`timescale 1ns/10ps
`default_nettype none
module hsct_cycle_timer_sva (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start_in,
    input wire logic manual_heat_key,
    input wire logic heat_req,
    input wire logic output_relay,
    input wire logic relay_icon,
    input wire logic ind_heat,
    input wire logic ind_cool,
    input wire logic cycle_done
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    a_icon_follows_relay: assert property (relay_icon == output_relay)
        else $error("relay icon differs from relay");
    a_start_launch: assert property ($rose(start_in) && !output_relay ##1 start_in |=> output_relay)
        else $error("start did not launch a cycle");
    a_abort_drop: assert property ($fell(start_in) |-> ##2 !output_relay)
        else $error("relay held after start release");
    a_no_launch: assert property (!output_relay && !start_in && !$past(start_in) |=> !output_relay)
        else $error("cycle began without start");
    a_manual_heat: assert property (manual_heat_key && !output_relay |-> heat_req)
        else $error("manual key gave no heat");
    a_phase_relay: assert property (ind_heat || ind_cool |-> output_relay && !(ind_heat && ind_cool))
        else $error("phase shown outside a cycle");
    a_cool_after_heat: assert property ($rose(ind_cool) |-> $past(ind_heat))
        else $error("cooling not entered from heating");
    a_heat_after_delay: assert property ($rose(ind_heat) |-> $past(output_relay) && !$past(ind_cool))
        else $error("heating without delay phase");
    a_done_ends_cool: assert property (cycle_done |-> $past(ind_cool) && !ind_cool && !output_relay)
        else $error("done pulse not at cooling end");
    a_done_pulse: assert property (cycle_done |=> !cycle_done)
        else $error("done pulse too long");
    c_done: cover property (cycle_done);
    c_abort: cover property ($fell(start_in) && ind_cool);
    c_manual: cover property (manual_heat_key && heat_req && !output_relay);
endmodule
`default_nettype wire

//--- verification/hsct_machine_ctl.sv
// Purpose: Machine control model driving start
// Assumes: Changes start at the falling edge
// Notes: Lag sets how slowly start follows run
`timescale 1ns/10ps
`default_nettype none
module hsct_machine_ctl (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       run,
    input  wire logic [3:0] lag,
    input  wire logic       cycle_done,
    output var  logic       start_in
);
    logic [3:0] wait_reg;
    logic       seen_reg;
    initial start_in = 1'b0;
    always @(negedge clk_sys) begin
        if (reset || !run) begin
            start_in <= 1'b0;
            wait_reg <= lag;
            seen_reg <= 1'b0;
        end else begin
            if (cycle_done) seen_reg <= 1'b1;
            if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
            start_in <= (wait_reg == 4'h0) && !seen_reg && !cycle_done;
        end
    end
endmodule
`default_nettype wire

//--- verification/hsct_cycle_timer_test.sv
// Purpose: Self-checking bench for the cycle timer
// Assumes: Zero seal time, cooling ended by zero cooling time or by temperature
// Notes: Tick periods are too long to simulate
`timescale 1ns/10ps
`default_nettype none
`include "hsct_params.svh"
module hsct_cycle_timer_test;
    logic                clk_sys = 1'b0;
    logic                reset = 1'b1;
    logic                run = 1'b0;
    logic [3:0]          lag = 4'h0;
    logic                manual_heat_key = 1'b0;
    logic                cfg_load = 1'b0;
    logic                factory_restore = 1'b0;
    logic [9:0]          target_temp = 10'h0c8;
    logic [9:0]          actual_temp = 10'h000;
    hsct_pkg::hsct_cfg_t cfg_in = '0;
    hsct_pkg::hsct_cfg_t cfg_out, c, e, dflt;
    logic [11:0]         band_tc;
    logic [9:0]          seal_remain;
    logic                start_in, heat_req, output_relay, relay_icon;
    logic                ind_heat, ind_cool, cycle_done;
    logic [11:0]         tcv [5] = '{`HSCT_TC_780, `HSCT_TC_1100, `HSCT_TC_1400,
                                     `HSCT_TC_1700, `HSCT_TC_3500};
    int                  n_errors = 0;
    int                  n_compared = 0;
    int                  cyc = 0;
    hsct_machine_ctl mc (.clk_sys, .reset, .run, .lag, .cycle_done, .start_in);
    hsct_cycle_timer uut (.clk_sys, .reset, .start_in, .manual_heat_key, .cfg_load, .cfg_in,
        .factory_restore, .target_temp, .actual_temp, .cfg_out, .band_tc, .heat_req,
        .output_relay, .relay_icon, .ind_heat, .ind_cool, .cycle_done, .seal_remain);
    always #5 clk_sys = ~clk_sys;
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            test_done;
        end
    end
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic load;
        cfg_in = c;
        cfg_load = 1'b1;
        tick(1);
        cfg_load = 1'b0;
    endtask
    task automatic cool(input hsct_pkg::hsct_cmode_t m, input logic [9:0] v, input logic [9:0] x);
        c.cool_mode = m;
        c.cool_value = v;
        load;
        chk("cool_value", 64'(x), 64'(cfg_out.cool_value));
    endtask
    task automatic finish_cycle(input int lim, input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (lim) begin
            tick(1);
            if (cycle_done === 1'b1) seen = 1'b1;
        end
        chk("cycle_done", 64'(exp), 64'(seen));
        run = 1'b0;
        tick(3);
        chk("output_relay", 64'h0, 64'(output_relay));
    endtask
    initial begin
        dflt = '{`HSCT_DELAY_DEF, `HSCT_SEAL_DEF, hsct_pkg::HSCT_COOL_ABS, `HSCT_CTEMP_MIN,
                 hsct_pkg::HSCT_RNG_300, `HSCT_RANGE_300, hsct_pkg::HSCT_TC_P1100,
                 `HSCT_TC_VAR_DEF, 1'b1, 4'h0};
        tick(2);
        reset = 1'b0;
        chk("cfg_out", dflt, cfg_out);
        chk("band_tc", 64'(`HSCT_TC_1100), 64'(band_tc));
        $display("test defaults done");
        c = '{10'h3ff, 10'h3ff, hsct_pkg::HSCT_COOL_ABS, 10'h000, hsct_pkg::HSCT_RNG_500,
              10'h3ff, hsct_pkg::HSCT_TC_VAR, 12'hfff, 1'b1, 4'h5};
        load;
        e = c;
        e.start_delay = `HSCT_DELAY_MAX;
        e.seal_time = `HSCT_SEAL_MAX;
        e.cool_value = `HSCT_CTEMP_MIN;
        e.temp_max = `HSCT_RANGE_500;
        e.tc_var = `HSCT_TC_VAR_MAX;
        chk("cfg_out", e, cfg_out);
        c.temp_range = hsct_pkg::HSCT_RNG_200;
        c.temp_max = 10'h064;
        c.tc_var = 12'h001;
        cool(hsct_pkg::HSCT_COOL_ABS, 10'h3ff, 10'h064);
        chk("tc_var", 64'(`HSCT_TC_VAR_MIN), 64'(cfg_out.tc_var));
        for (int i = 0; i < 5; i++) begin
            c.tc_sel = hsct_pkg::hsct_tcsel_t'(i);
            load;
            chk("band_tc", 64'(tcv[i]), 64'(band_tc));
            chk("tc_var", 64'(`HSCT_TC_VAR_MIN), 64'(cfg_out.tc_var));
        end
        cool(hsct_pkg::HSCT_COOL_REL, 10'h046, `HSCT_PCT_MIN);
        cool(hsct_pkg::HSCT_COOL_REL, 10'h0ff, `HSCT_PCT_MAX);
        cool(hsct_pkg::HSCT_COOL_REL, 10'h00a, `HSCT_PCT_MIN);
        cool(hsct_pkg::HSCT_COOL_TIME, 10'h001, `HSCT_CTIME_DEF);
        cool(hsct_pkg::HSCT_COOL_TIME, 10'h3ff, `HSCT_CTIME_MAX);
        $display("test settings done");
        factory_restore = 1'b1;
        tick(1);
        factory_restore = 1'b0;
        e = dflt;
        e.language = 4'h5;
        chk("cfg_out", e, cfg_out);
        $display("test restore done");
        c = e;
        c.seal_time = 10'h000;
        c.seal_at_temp = 1'b0;
        cool(hsct_pkg::HSCT_COOL_TIME, 10'h000, `HSCT_CTIME_DEF);
        cool(hsct_pkg::HSCT_COOL_TIME, 10'h000, 10'h000);
        run = 1'b1;
        finish_cycle(20, 1'b1);
        cool(hsct_pkg::HSCT_COOL_ABS, 10'h03c, `HSCT_CTEMP_MIN);
        cool(hsct_pkg::HSCT_COOL_ABS, 10'h03c, 10'h03c);
        actual_temp = 10'h064;
        lag = 4'h3;
        run = 1'b1;
        tick(20);
        chk("ind_cool", 64'h1, 64'(ind_cool));
        chk("relay_icon", 64'h1, 64'(relay_icon));
        manual_heat_key = 1'b1;
        load;
        actual_temp = 10'h03c;
        tick(5);
        manual_heat_key = 1'b0;
        chk("ind_cool", 64'h1, 64'(ind_cool));
        actual_temp = 10'h03b;
        finish_cycle(10, 1'b1);
        $display("test absolute done");
        cool(hsct_pkg::HSCT_COOL_REL, 10'h03c, `HSCT_PCT_MIN);
        cool(hsct_pkg::HSCT_COOL_REL, 10'h03c, 10'h03c);
        target_temp = 10'h0b4;
        actual_temp = 10'h06d;
        lag = 4'h0;
        run = 1'b1;
        tick(10);
        chk("ind_cool", 64'h1, 64'(ind_cool));
        actual_temp = 10'h06c;
        finish_cycle(10, 1'b1);
        $display("test relative done");
        c.seal_at_temp = 1'b1;
        load;
        target_temp = 10'h0c8;
        actual_temp = 10'h0bd;
        run = 1'b1;
        tick(10);
        chk("ind_heat", 64'h1, 64'(ind_heat));
        chk("heat_req", 64'h1, 64'(heat_req));
        actual_temp = 10'h0be;
        tick(5);
        chk("ind_cool", 64'h1, 64'(ind_cool));
        run = 1'b0;
        finish_cycle(10, 1'b0);
        chk("seal_remain", 64'h0, 64'(seal_remain));
        $display("test abort done");
        manual_heat_key = 1'b1;
        tick(5);
        chk("heat_req", 64'h1, 64'(heat_req));
        chk("output_relay", 64'h0, 64'(output_relay));
        manual_heat_key = 1'b0;
        $display("test manual done");
        test_done;
    end
endmodule
bind hsct_cycle_timer hsct_cycle_timer_sva u_sva (.clk_sys, .reset, .start_in,
    .manual_heat_key, .heat_req, .output_relay, .relay_icon, .ind_heat, .ind_cool,
    .cycle_done);
`default_nettype wire
